/* hdl/cpfad_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - Opcode 10001101 with a mod/reg/r-m byte is load-effective-address and runs 3 clocks.
// RL2 - Opcode 11000101 with a memory mod loads a pointer with the data segment, 7 or 21 clocks.
// RL3 - Opcode 11000100 with a memory mod loads a pointer with the extra segment, 7 or 21 clocks.
// RL4 - Opcode 10011111 copies the low flag byte to the high accumulator byte in 2 clocks.
// RL5 - Opcode 10011110 writes the high accumulator byte into the low flag byte in 2 clocks.
// RL6 - Add-with-carry decodes from 000100dw (2 or 7 clocks), 100000sw with reg 010 (3 or 7 clocks), and 0001010w (3 clocks).
// RL7 - Bit w selects byte or word, bit d the direction, and bit s sign-extends a byte immediate.
module cpfad_decoder
  import cpfad_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             byte_valid_in,
  input  wire logic [7:0]       byte_in,
  input  wire logic             prot_mode_in,
  output logic                  byte_ready_out,
  output logic                  op_valid_out,
  output cpfad_kind_t           op_kind_out,
  output logic                  op_prot_out,
  output logic                  op_word_out,
  output logic                  op_dir_out,
  output logic                  op_sext_out,
  output logic [1:0]            op_mod_out,
  output logic [2:0]            op_reg_out,
  output logic [2:0]            op_rm_out,
  output logic [15:0]           op_disp_out,
  output logic [15:0]           op_imm_out,
  output logic [CLK_W-1:0]      op_clocks_out,
  output logic                  exec_busy_out,
  output logic                  exec_done_out,
  output logic                  bad_op_out
);

  // ==========================================================================
  // Helpers
  function automatic cpfad_kind_t classify(input logic [7:0] b);
    if (b == OP_LOAD_EA)                classify = K_LOAD_EA;       // [RL1]
    else if (b == OP_LOAD_PTR_DS)       classify = K_LOAD_PTR_DS;   // [RL2]
    else if (b == OP_LOAD_PTR_ES)       classify = K_LOAD_PTR_ES;   // [RL3]
    else if (b == OP_FLAGS_TO_AH)       classify = K_FLAGS_TO_AH;   // [RL4]
    else if (b == OP_AH_TO_FLAGS)       classify = K_AH_TO_FLAGS;   // [RL5]
    else if (b[7:2] == OP_ADC_RM_HI)    classify = K_ADC_RM;        // [RL6]
    else if (b[7:2] == OP_GRP_IMM_HI)   classify = K_ADC_IMM_RM;    // [RL6]
    else if (b[7:1] == OP_ADC_ACC_HI)   classify = K_ADC_IMM_ACC;   // [RL6]
    else                                classify = K_NONE;
  endfunction

  function automatic logic [1:0] disp_len(input logic [1:0] md, input logic [2:0] rm);
    if (md == MOD_DISP8)                               disp_len = DISP_BYTE;
    else if (md == MOD_REG)                            disp_len = DISP_NONE;
    else if (md == MOD_NO_DISP && rm != RM_DIRECT)     disp_len = DISP_NONE;
    else                                               disp_len = DISP_WORD;
  endfunction

  function automatic logic [CLK_W-1:0] clocks_of(input cpfad_kind_t k, input logic reg_form,
                                                 input logic prot);
    case (k)
      K_LOAD_EA:     clocks_of = CLK_LOAD_EA;                                  // [RL1]
      K_LOAD_PTR_DS,
      K_LOAD_PTR_ES: clocks_of = prot ? CLK_PTR_PROT : CLK_PTR_REAL;          // [RL2] [RL3]
      K_FLAGS_TO_AH,
      K_AH_TO_FLAGS: clocks_of = CLK_FLAGS_XFER;                               // [RL4] [RL5]
      K_ADC_RM:      clocks_of = reg_form ? CLK_ADC_REG : CLK_ADC_MEM;
      K_ADC_IMM_RM:  clocks_of = reg_form ? CLK_ADC_IMM_REG : CLK_ADC_IMM_MEM;
      K_ADC_IMM_ACC: clocks_of = CLK_ADC_IMM_ACC;                              // [RL6]
      default:       clocks_of = CLK_ONE;
    endcase
  endfunction

  // ==========================================================================
  // State
  cpfad_state_t      state_q, state_d;
  cpfad_kind_t       kind_q, kind_now;
  logic [7:0]        opc_q;
  logic [1:0]        mod_q;
  logic [2:0]        reg_q, rm_q;
  logic [1:0]        left_q;
  logic              disp_first_q;
  logic [15:0]       disp_q, imm_q;
  logic [CLK_W-1:0]  cnt_q, clocks_q;
  logic              ready_q, valid_q, prot_q, busy_q, done_q, bad_q;
  logic              sext_q, dir_q;
  logic              accept, finish, bad, reg_form_now, imm_sext, imm_two;

  assign accept   = byte_valid_in && ready_q;
  assign kind_now = (state_q == S_OPCODE) ? classify(byte_in) : kind_q;
  assign reg_form_now = (state_q == S_MODRM) ? (byte_in[MOD_MSB:MOD_LSB] == MOD_REG)
                                             : (mod_q == MOD_REG);
  // s only widens a byte immediate into a word operand
  assign imm_sext = (kind_q == K_ADC_IMM_RM) && opc_q[BIT_S] && opc_q[BIT_W];       // [RL7]
  assign imm_two  = opc_q[BIT_W] && !((kind_q == K_ADC_IMM_RM) && opc_q[BIT_S]);   // [RL7]

  // ==========================================================================
  // Sequencing
  always_comb
  begin
    state_d = state_q;
    finish  = 1'b0;
    bad     = 1'b0;
    case (state_q)
      S_OPCODE:
      begin
        if (accept)
        begin
          if (kind_now == K_NONE)
            bad = 1'b1;
          else if (kind_now == K_ADC_IMM_ACC)
            state_d = S_IMM_LO;
          else if (kind_now == K_FLAGS_TO_AH || kind_now == K_AH_TO_FLAGS)
            finish = 1'b1;                                                    // [RL4] [RL5]
          else
            state_d = S_MODRM;
        end
      end
      S_MODRM:
      begin
        if (accept)
        begin
          if (kind_q == K_ADC_IMM_RM && byte_in[REG_MSB:REG_LSB] != GRP_IMM_ADC)
          begin
            bad     = 1'b1;                                                   // [RL6]
            state_d = S_OPCODE;
          end
          else if ((kind_q == K_LOAD_PTR_DS || kind_q == K_LOAD_PTR_ES) &&
                   byte_in[MOD_MSB:MOD_LSB] == MOD_REG)
          begin
            bad     = 1'b1;                                                   // [RL2] [RL3]
            state_d = S_OPCODE;
          end
          else if (disp_len(byte_in[MOD_MSB:MOD_LSB], byte_in[RM_MSB:RM_LSB]) != DISP_NONE)
            state_d = S_DISP;
          else if (kind_q == K_ADC_IMM_RM)
            state_d = S_IMM_LO;
          else
            finish = 1'b1;
        end
      end
      S_DISP:
      begin
        if (accept && left_q == DISP_BYTE)
        begin
          if (kind_q == K_ADC_IMM_RM)
            state_d = S_IMM_LO;
          else
            finish = 1'b1;
        end
      end
      S_IMM_LO:
      begin
        if (accept)
        begin
          if (imm_two)
            state_d = S_IMM_HI;
          else
            finish = 1'b1;
        end
      end
      S_IMM_HI:
      begin
        if (accept)
          finish = 1'b1;
      end
      S_EXEC:
      begin
        if (cnt_q == '0)
          state_d = S_OPCODE;
      end
      default: state_d = S_OPCODE;
    endcase
    if (finish)
      state_d = S_EXEC;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= S_OPCODE;
      ready_q <= 1'b1;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      valid_q <= 1'b0;
      bad_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // No new bytes are taken while an operation is timing out
      ready_q <= (state_d != S_EXEC);
      busy_q  <= (state_d == S_EXEC);
      done_q  <= (state_q == S_EXEC) && (cnt_q == '0);
      valid_q <= finish;
      bad_q   <= bad;
    end
  end

  // ==========================================================================
  // Instruction fields
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      kind_q <= K_NONE;
      sext_q <= 1'b0;
      dir_q  <= 1'b0;
      opc_q  <= 8'h00;
      mod_q  <= 2'h0;
      reg_q  <= 3'h0;
      rm_q   <= 3'h0;
    end
    else if (accept && state_q == S_OPCODE)
    begin
      kind_q <= kind_now;
      // Registered so the outputs come straight from flip-flops
      sext_q <= (kind_now == K_ADC_IMM_RM) && byte_in[BIT_S] && byte_in[BIT_W];     // [RL7]
      dir_q  <= (kind_now == K_ADC_RM) && byte_in[BIT_D];                           // [RL7]
      opc_q  <= byte_in;
      mod_q  <= 2'h0;
      reg_q  <= 3'h0;
      rm_q   <= 3'h0;
    end
    else if (accept && state_q == S_MODRM)
    begin
      mod_q <= byte_in[MOD_MSB:MOD_LSB];
      reg_q <= byte_in[REG_MSB:REG_LSB];
      rm_q  <= byte_in[RM_MSB:RM_LSB];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      left_q       <= DISP_NONE;
      disp_first_q <= 1'b1;
      disp_q       <= 16'h0000;
    end
    else if (accept && state_q == S_OPCODE)
      disp_q <= 16'h0000;
    else if (accept && state_q == S_MODRM)
    begin
      left_q       <= disp_len(byte_in[MOD_MSB:MOD_LSB], byte_in[RM_MSB:RM_LSB]);
      disp_first_q <= 1'b1;
    end
    else if (accept && state_q == S_DISP)
    begin
      left_q       <= left_q - DISP_BYTE;
      disp_first_q <= 1'b0;
      if (disp_first_q)
        disp_q <= {(mod_q == MOD_DISP8) ? {8{byte_in[7]}} : 8'h00, byte_in};
      else
        disp_q[15:8] <= byte_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      imm_q <= 16'h0000;
    else if (accept && state_q == S_OPCODE)
      imm_q <= 16'h0000;
    else if (accept && state_q == S_IMM_LO)
      imm_q <= {imm_sext ? {8{byte_in[7]}} : 8'h00, byte_in};                  // [RL7]
    else if (accept && state_q == S_IMM_HI)
      imm_q[15:8] <= byte_in;
  end

  // ==========================================================================
  // Execution timing
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q    <= '0;
      clocks_q <= '0;
      prot_q   <= 1'b0;
    end
    else if (finish)
    begin
      // Mode is sampled at the last byte so a switch mid-fetch is harmless
      clocks_q <= clocks_of(kind_now, reg_form_now, prot_mode_in);
      cnt_q    <= clocks_of(kind_now, reg_form_now, prot_mode_in) - CLK_ONE;
      prot_q   <= prot_mode_in;
    end
    else if (state_q == S_EXEC && cnt_q != '0)
      cnt_q <= cnt_q - CLK_ONE;
  end

  assign byte_ready_out = ready_q;
  assign op_valid_out   = valid_q;
  assign op_kind_out    = kind_q;
  assign op_prot_out    = prot_q;
  assign op_word_out    = opc_q[BIT_W];                                         // [RL7]
  assign op_dir_out     = dir_q;                                                 // [RL7]
  assign op_sext_out    = sext_q;
  assign op_mod_out     = mod_q;
  assign op_reg_out     = reg_q;
  assign op_rm_out      = rm_q;
  assign op_disp_out    = disp_q;
  assign op_imm_out     = imm_q;
  assign op_clocks_out  = clocks_q;
  assign exec_busy_out  = busy_q;
  assign exec_done_out  = done_q;
  assign bad_op_out     = bad_q;

  // ==========================================================================
  // Checks
  logic [CLK_W-1:0] busy_run_q;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      busy_run_q <= '0;
    else
      busy_run_q <= busy_q ? busy_run_q + CLK_ONE : '0;
  end

  sequence busy_for_two;
    exec_busy_out [*2] ##1 !exec_busy_out;
  endsequence

  sequence busy_for_three;
    exec_busy_out [*3] ##1 !exec_busy_out;
  endsequence

  a_load_ea_time: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL1]
    op_valid_out && op_kind_out == K_LOAD_EA |-> busy_for_three)
    else $error("load effective address not 3 clocks");

  a_ptr_ds_time: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL2]
    op_valid_out && op_kind_out == K_LOAD_PTR_DS |->
      op_mod_out != MOD_REG && op_clocks_out == (op_prot_out ? CLK_PTR_PROT : CLK_PTR_REAL))
    else $error("data segment pointer load timing wrong");

  a_ptr_es_time: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
    op_valid_out && op_kind_out == K_LOAD_PTR_ES |->
      op_mod_out != MOD_REG && op_clocks_out == (op_prot_out ? CLK_PTR_PROT : CLK_PTR_REAL))
    else $error("extra segment pointer load timing wrong");

  a_flags_to_ah: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    state_q == S_OPCODE && accept && byte_in == OP_FLAGS_TO_AH |->
      ##1 op_valid_out && op_kind_out == K_FLAGS_TO_AH ##0 busy_for_two)
    else $error("flags to high accumulator not 2 clocks");

  a_ah_to_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    state_q == S_OPCODE && accept && byte_in == OP_AH_TO_FLAGS |->
      ##1 op_valid_out && op_kind_out == K_AH_TO_FLAGS ##0 busy_for_two)
    else $error("high accumulator to flags not 2 clocks");

  a_adc_acc_forms: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL6]
    op_valid_out && op_kind_out == K_ADC_IMM_ACC |-> busy_for_three)
    else $error("accumulator add-with-carry not 3 clocks");

  a_adc_grp_reg: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL6]
    op_valid_out && op_kind_out == K_ADC_IMM_RM |-> op_reg_out == GRP_IMM_ADC)
    else $error("immediate add-with-carry with wrong reg field");

  a_imm_sign_ext: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL7]
    op_valid_out && op_kind_out == K_ADC_IMM_RM && op_sext_out |->
      op_imm_out[15:8] == {8{op_imm_out[7]}} && op_word_out)
    else $error("byte immediate not sign-extended");

  a_busy_matches: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL2]
    $fell(exec_busy_out) |-> busy_run_q == op_clocks_out && exec_done_out)
    else $error("busy length differs from clock count");

endmodule

`default_nettype wire

/* hdl/cpfad_pkg.sv */
package cpfad_pkg;

  // ==========================================================================
  // Opcode patterns
  localparam logic [7:0] OP_LOAD_EA      = 8'h8D;  // 10001101
  localparam logic [7:0] OP_LOAD_PTR_DS  = 8'hC5;  // 11000101
  localparam logic [7:0] OP_LOAD_PTR_ES  = 8'hC4;  // 11000100
  localparam logic [7:0] OP_FLAGS_TO_AH  = 8'h9F;  // 10011111
  localparam logic [7:0] OP_AH_TO_FLAGS  = 8'h9E;  // 10011110
  localparam logic [5:0] OP_ADC_RM_HI    = 6'h04;  // 000100dw
  localparam logic [5:0] OP_GRP_IMM_HI   = 6'h20;  // 100000sw
  localparam logic [6:0] OP_ADC_ACC_HI   = 7'h0A;  // 0001010w
  localparam logic [2:0] GRP_IMM_ADC     = 3'h2;   // reg field 010

  // ==========================================================================
  // Mod/reg/r-m field layout
  localparam int unsigned MOD_MSB = 7;
  localparam int unsigned MOD_LSB = 6;
  localparam int unsigned REG_MSB = 5;
  localparam int unsigned REG_LSB = 3;
  localparam int unsigned RM_MSB  = 2;
  localparam int unsigned RM_LSB  = 0;
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8   = 2'h1;
  localparam logic [1:0] MOD_REG     = 2'h3;
  localparam logic [2:0] RM_DIRECT   = 3'h6;
  localparam int unsigned BIT_W = 0;
  localparam int unsigned BIT_D = 1;
  localparam int unsigned BIT_S = 1;

  // ==========================================================================
  // Clock counts
  localparam int unsigned CLK_W = 5;
  localparam logic [CLK_W-1:0] CLK_LOAD_EA      = 5'h03;
  localparam logic [CLK_W-1:0] CLK_PTR_REAL     = 5'h07;
  localparam logic [CLK_W-1:0] CLK_PTR_PROT     = 5'h15;
  localparam logic [CLK_W-1:0] CLK_FLAGS_XFER   = 5'h02;
  localparam logic [CLK_W-1:0] CLK_ADC_REG      = 5'h02;
  localparam logic [CLK_W-1:0] CLK_ADC_MEM      = 5'h07;
  localparam logic [CLK_W-1:0] CLK_ADC_IMM_REG  = 5'h03;
  localparam logic [CLK_W-1:0] CLK_ADC_IMM_MEM  = 5'h07;
  localparam logic [CLK_W-1:0] CLK_ADC_IMM_ACC  = 5'h03;
  localparam logic [CLK_W-1:0] CLK_ONE          = 5'h01;

  localparam logic [1:0] DISP_NONE = 2'h0;
  localparam logic [1:0] DISP_BYTE = 2'h1;
  localparam logic [1:0] DISP_WORD = 2'h2;

  typedef enum logic [3:0] {
    K_NONE,
    K_LOAD_EA,
    K_LOAD_PTR_DS,
    K_LOAD_PTR_ES,
    K_FLAGS_TO_AH,
    K_AH_TO_FLAGS,
    K_ADC_RM,
    K_ADC_IMM_RM,
    K_ADC_IMM_ACC
  } cpfad_kind_t;

  typedef enum logic [2:0] {
    S_OPCODE,
    S_MODRM,
    S_DISP,
    S_IMM_LO,
    S_IMM_HI,
    S_EXEC
  } cpfad_state_t;

endpackage

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cpfad_pkg::*;
;
  typedef struct packed {
    logic        bad;
    cpfad_kind_t kind;
    logic [4:0]  clks;
    logic [3:0]  bits;
    logic [7:0]  modrm;
    logic [15:0] disp;
    logic [15:0] imm;
  } cpfad_exp_t;

  logic             clk_in;
  logic             rst_n_in;
  logic             byte_valid_in;
  logic             prot_mode_in;
  logic [7:0]       byte_in;
  logic             byte_ready_out;
  logic             op_valid_out;
  cpfad_kind_t      op_kind_out;
  logic             op_prot_out;
  logic             op_word_out;
  logic             op_dir_out;
  logic             op_sext_out;
  logic [1:0]       op_mod_out;
  logic [2:0]       op_reg_out;
  logic [2:0]       op_rm_out;
  logic [15:0]      op_disp_out;
  logic [15:0]      op_imm_out;
  logic [CLK_W-1:0] op_clocks_out;
  logic             exec_busy_out;
  logic             exec_done_out;
  logic             bad_op_out;
  int               errors;
  int               checks_done;
  int               busy_n;
  int               busy_want;
  logic             was_busy;
  cpfad_exp_t       exp_q[$];
  cpfad_exp_t       cur_e;

  cpfad_decoder dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .byte_valid_in(byte_valid_in), .byte_in(byte_in),
    .prot_mode_in(prot_mode_in), .byte_ready_out(byte_ready_out), .op_valid_out(op_valid_out),
    .op_kind_out(op_kind_out), .op_prot_out(op_prot_out), .op_word_out(op_word_out),
    .op_dir_out(op_dir_out), .op_sext_out(op_sext_out), .op_mod_out(op_mod_out),
    .op_reg_out(op_reg_out), .op_rm_out(op_rm_out), .op_disp_out(op_disp_out),
    .op_imm_out(op_imm_out), .op_clocks_out(op_clocks_out), .exec_busy_out(exec_busy_out),
    .exec_done_out(exec_done_out), .bad_op_out(bad_op_out));

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Byte stream driver: a byte holds until an edge samples ready high
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    byte_in       <= b;
    byte_valid_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (byte_ready_out !== 1'b1 && n < 200);
    if (n >= 200)
      chk(32'h1, 32'h0);
  endtask

  task automatic run_op(input cpfad_kind_t k, input logic [7:0] opc, input logic has_m,
                        input logic [7:0] m, input int nimm, input logic [15:0] imm,
                        input logic pr, input logic bad, input logic [4:0] clks);
    cpfad_exp_t  e;
    int          nd;
    logic [15:0] d;
    nd = 0;
    d  = 16'($urandom);
    if (has_m && !bad)
      nd = (m[7:6] == 2'h1) ? 1 : (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) ? 2 : 0;
    e.bad   = bad;
    e.kind  = k;
    e.clks  = clks;
    e.bits  = {opc[0], (k == K_ADC_RM) & opc[1], (k == K_ADC_IMM_RM) & opc[1] & opc[0], pr};
    e.modrm = has_m ? m : 8'h00;
    e.disp  = (nd == 1) ? {{8{d[7]}}, d[7:0]} : (nd == 2) ? d : 16'h0000;
    e.imm   = (nimm == 2) ? imm : (nimm == 0) ? 16'h0000 : e.bits[1] ? {{8{imm[7]}}, imm[7:0]}
            : {8'h00, imm[7:0]};
    exp_q.push_back(e);
    @(posedge clk_in);
    prot_mode_in <= pr;
    put(opc);
    if (has_m)
      put(m);
    for (int i = 0; i < nd; i++)
      put(d[8*i +: 8]);
    for (int i = 0; i < nimm && !bad; i++)
      put(imm[8*i +: 8]);
    byte_valid_in <= 1'b0;
  endtask

  // ==========================================================================
  // Result watcher, sampling on the falling edge where outputs are settled
  always @(negedge clk_in)
  begin
    if (rst_n_in !== 1'b1)
    begin
      was_busy = 1'b0;
      busy_n   = 0;
    end
    else
    begin
      if (op_valid_out === 1'b1 || bad_op_out === 1'b1)
      begin
        chk(32'(exp_q.size() > 0), 32'h1);
        if (exp_q.size() > 0)
        begin
          cur_e = exp_q.pop_front();
          chk(32'({op_valid_out, bad_op_out}), 32'({~cur_e.bad, cur_e.bad}));
          if (cur_e.bad == 1'b0)
          begin
            chk(32'(op_kind_out), 32'(cur_e.kind));
            chk(32'(op_clocks_out), 32'(cur_e.clks));
            chk(32'({op_word_out, op_dir_out, op_sext_out, op_prot_out}), 32'(cur_e.bits));
            chk(32'({op_mod_out, op_reg_out, op_rm_out}), 32'(cur_e.modrm));
            chk({op_disp_out, op_imm_out}, {cur_e.disp, cur_e.imm});
            busy_want = cur_e.clks;
            busy_n    = 0;
          end
        end
      end
      if (exec_busy_out === 1'b1)
      begin
        busy_n++;
        chk(32'(byte_ready_out), 32'h0);
      end
      if (was_busy && exec_busy_out !== 1'b1)
      begin
        chk(busy_n, busy_want);
        chk(32'(exec_done_out), 32'h1);
      end
      was_busy = (exec_busy_out === 1'b1);
    end
  end

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (30000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end

  initial
  begin
    logic [7:0] m;
    logic [7:0] opc;
    int         seed;
    errors        = 0;
    checks_done   = 0;
    rst_n_in      = 1'b0;
    byte_valid_in = 1'b0;
    byte_in       = 8'h00;
    prot_mode_in  = 1'b0;
    seed          = $urandom(32'h166A3A03);
    repeat (12) @(posedge clk_in);
    chk(32'({byte_ready_out, op_valid_out, exec_busy_out, bad_op_out, op_kind_out}), 32'h80);
    rst_n_in <= 1'b1;
    $display("test reset done");
    for (int p = 0; p < 2; p++)
    begin
      run_op(K_FLAGS_TO_AH, 8'h9F, 0, 8'h00, 0, 16'h0000, p[0], 0, 5'h02);
      run_op(K_AH_TO_FLAGS, 8'h9E, 0, 8'h00, 0, 16'h0000, p[0], 0, 5'h02);
    end
    $display("test flag transfers done");
    for (int i = 0; i < 10; i++)
    begin
      m = 8'($urandom);
      m[7:6] = i[1:0];
      if (i == 4)
        m = {2'h0, m[5:3], 3'h6};
      run_op(K_LOAD_EA, 8'h8D, 1, m, 0, 16'h0000, i[2], 0, 5'h03);
    end
    $display("test effective address done");
    for (int i = 0; i < 8; i++)
    begin
      m = 8'($urandom);
      m[7:6] = 2'(i % 3);
      run_op(K_LOAD_PTR_DS, 8'hC5, 1, m, 0, 16'h0000, i[0], 0, i[0] ? 5'h15 : 5'h07);
      run_op(K_LOAD_PTR_ES, 8'hC4, 1, m, 0, 16'h0000, i[1], 0, i[1] ? 5'h15 : 5'h07);
    end
    m = {2'h3, 6'($urandom)};
    run_op(K_NONE, 8'hC5, 1, m, 0, 16'h0000, 0, 1, 5'h00);
    run_op(K_NONE, 8'hC4, 1, m, 0, 16'h0000, 1, 1, 5'h00);
    $display("test pointer loads done");
    for (int i = 0; i < 16; i++)
    begin
      m = 8'($urandom);
      if (i[2])
        m[7:6] = 2'h3;
      opc = {6'h04, i[1:0]};
      run_op(K_ADC_RM, opc, 1, m, 0, 16'h0000, i[3], 0, (m[7:6] == 2'h3) ? 5'h02 : 5'h07);
      opc = {6'h20, i[1:0]};
      m[5:3] = 3'h2;
      run_op(K_ADC_IMM_RM, opc, 1, m, (i[1:0] == 2'h1) ? 2 : 1, 16'($urandom), i[3], 0,
             (m[7:6] == 2'h3) ? 5'h03 : 5'h07);
    end
    for (int i = 0; i < 4; i++)
      run_op(K_ADC_IMM_ACC, {7'h0A, i[0]}, 0, 8'h00, 1 + i[0], 16'($urandom), i[1], 0, 5'h03);
    run_op(K_NONE, 8'h83, 1, 8'hE8, 0, 16'h0000, 0, 1, 5'h00);
    run_op(K_NONE, 8'h9C, 0, 8'h00, 0, 16'h0000, 0, 1, 5'h00);
    run_op(K_NONE, 8'h00, 0, 8'h00, 0, 16'h0000, 0, 1, 5'h00);
    $display("test add with carry done");
    run_op(K_LOAD_PTR_DS, 8'hC5, 1, 8'h07, 0, 16'h0000, 1, 0, 5'h15);
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(32'({byte_ready_out, exec_busy_out, exec_done_out, op_kind_out}), 32'h40);
    rst_n_in <= 1'b1;
    run_op(K_FLAGS_TO_AH, 8'h9F, 0, 8'h00, 0, 16'h0000, 0, 0, 5'h02);
    repeat (40) @(posedge clk_in);
    chk(exp_q.size(), 0);
    $display("test reset in flight done");
    report_and_stop();
  end
endmodule

`default_nettype wire
